// *** bench/pbwg_macro_model.sv ***
// macro side model: one buffer ram write pulse per rising edge of go_i
// assumes the bench clock and reset; pulse lasts one cpu clock
`timescale 1ns/100ps
module pbwg_macro_model (
    input  wire logic clock_i,
    input  wire logic resetn_i,
    input  wire logic go_i,
    output logic      buf_write_o
);
    logic go_q;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            go_q        <= 1'h0;
            buf_write_o <= 1'h0;
        end else begin
            go_q        <= go_i;
            buf_write_o <= go_i && !go_q;
        end
    end
endmodule : pbwg_macro_model

// *** bench/pbwg_wait_gen_asserts.sv ***
// timing checks on the ports of pbwg_wait_gen
// assumes it is bound to the design by the bench top file
`timescale 1ns/100ps
module pbwg_wait_gen_asserts #(
    parameter logic [3:0] BUF_MACRO_DIV = 4'h8
) (
    input wire logic       clock_i,
    input wire logic       resetn_i,
    input wire logic       access_req_i,
    input wire logic       access_write_i,
    input wire logic [3:0] access_target_i,
    input wire logic       converter_speed_select_i,
    input wire logic [2:0] cpu_clock_shift_i,
    input wire logic       main_clock_stop_bit_i,
    input wire logic       macro_buf_write_i,
    input wire logic       wait_o,
    input wire logic       access_error_o
);
    wire logic       acc = access_req_i && !wait_o;
    wire logic       wr  = acc && access_write_i;
    wire logic       rd  = acc && !access_write_i;
    wire logic [3:0] t   = access_target_i;
    wire logic       cw  = wr && t >= 4'h4 && t <= 4'h7 && cpu_clock_shift_i == 3'h0;
    wire logic       sa  = acc && main_clock_stop_bit_i;
    logic [7:0] gap;
    // saturates so an old macro write never wraps back into range
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) gap <= 8'hFF;
        else if (macro_buf_write_i) gap <= 8'h01;
        else if (gap != 8'hFF) gap <= gap + 8'h01;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    AST_WDT: assert property (wr && t == 4'h1 |=> wait_o [*3] ##1 !wait_o)
        else $error("watchdog write stall length wrong");
    AST_UART: assert property (rd && (t == 4'h2 || t == 4'h3) |=> wait_o ##1 !wait_o)
        else $error("uart status read stall length wrong");
    AST_NOWAIT: assert property (acc && (t == 4'h0 || t > 4'h9) |=> !wait_o)
        else $error("stall on an access without wait");
    AST_CONV_FAST: assert property (cw && converter_speed_select_i |=> wait_o [*5] ##1 !wait_o)
        else $error("fast converter write stall wrong");
    AST_CONV_SLOW: assert property (cw && !converter_speed_select_i |=> wait_o [*8] ##1 wait_o ##1 !wait_o)
        else $error("slow converter write stall wrong");
    AST_RESULT: assert property (rd && t == 4'h8 |=> wait_o ##[1:9] !wait_o)
        else $error("result read stall out of range");
    AST_BUF_MAX: assert property (wr && t == 4'h9 |=> ##[0:41] !wait_o)
        else $error("buffer write stall too long");
    AST_BUF_GAP: assert property (wr && t == 4'h9 && !macro_buf_write_i
        && gap >= {4'h0, BUF_MACRO_DIV} * 8'h05 |=> !wait_o)
        else $error("buffer write stalled after quiet macro");
    AST_ERR: assert property (sa && access_write_i && t == 4'h1 |=> access_error_o)
        else $error("missing access error");
    AST_ERR_CAUSE: assert property (access_error_o |-> $past(sa))
        else $error("access error without cause");
    AST_CAUSE: assert property ($rose(wait_o) |-> $past(access_req_i))
        else $error("stall without an access");
endmodule : pbwg_wait_gen_asserts

// *** bench/pbwg_wait_gen_tb.sv ***
// self-checking bench for the wait generator, one task per scenario
// assumes pbwg_macro_model and pbwg_wait_gen_asserts are compiled first
`timescale 1ns/100ps
module pbwg_wait_gen_tb;
    logic       clk, rst_n, req, wr, speed, stop, go, mbw, wt, err;
    logic [3:0] tgt;
    logic [2:0] shift;
    int         n_mismatch   = 0;
    int         total_checks = 0;
    pbwg_wait_gen #(.BUF_MACRO_DIV(4'h8)) uut (.clock_i(clk), .resetn_i(rst_n),
        .access_req_i(req), .access_write_i(wr), .access_target_i(tgt),
        .converter_speed_select_i(speed), .cpu_clock_shift_i(shift),
        .main_clock_stop_bit_i(stop), .macro_buf_write_i(mbw), .wait_o(wt), .access_error_o(err));
    pbwg_macro_model mac (.clock_i(clk), .resetn_i(rst_n), .go_i(go), .buf_write_o(mbw));
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task automatic cmp_n(input string what, input int exp, input int got);
        total_checks++;
        if (exp != got) begin
            n_mismatch++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask : cmp_n
    task automatic cmp_b(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp_b
    // one access, then count the stall in cpu clocks
    task automatic access(input logic w, input logic [3:0] t, input int en, input logic ee);
        int n;
        n = 0;
        @(posedge clk);
        req <= 1'h1;
        wr  <= w;
        tgt <= t;
        @(posedge clk);
        req <= 1'h0;
        #1 cmp_b("access error", ee, err);
        while (wt === 1'h1 && n < 300) begin
            n++;
            @(posedge clk);
            #1;
        end
        cmp_n("wait clocks", en, n);
    endtask : access
    function automatic int exp_c(input int s, input int k);
        int q, r;
        q = (s ? 4 : 8) >> k;
        r = (s ? 4 : 8) - (q << k);
        if (2 * r > (1 << k)) q++;
        return q + 1;
    endfunction : exp_c
    task automatic t_fixed;
        access(1'h1, 4'h1, 3, 1'h0);
        access(1'h0, 4'h1, 0, 1'h0);
        access(1'h0, 4'h2, 1, 1'h0);
        access(1'h0, 4'h3, 1, 1'h0);
        access(1'h1, 4'h3, 0, 1'h0);
        access(1'h1, 4'h2, 0, 1'h0);
        access(1'h0, 4'hC, 0, 1'h0);
        $display("fixed stalls done");
    endtask : t_fixed
    task automatic t_conv;
        int c;
        for (int s = 0; s < 2; s++) for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            speed <= s[0];
            shift <= k[2:0];
            c = exp_c(s, k);
            for (int t = 4; t < 8; t++) access(1'h1, t[3:0], c == 1 ? 0 : c, 1'h0);
            access(1'h0, 4'h8, c, 1'h0);
            access(1'h0, 4'h4, 0, 1'h0);
            access(1'h1, 4'h8, 0, 1'h0);
        end
        $display("converter stalls done");
    endtask : t_conv
    task automatic t_buf;
        int d [3] = '{0, 39, 40};
        @(posedge clk);
        shift <= 3'h0;
        access(1'h1, 4'h9, 0, 1'h0);
        access(1'h0, 4'h9, 0, 1'h0);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            go <= 1'h0;
            @(posedge clk);
            go <= 1'h1;
            repeat (d[i]) @(posedge clk);
            access(1'h1, 4'h9, d[i] < 40 ? 5 * 8 + 1 - d[i] : 0, 1'h0);
        end
        $display("buffer stalls done");
    endtask : t_buf
    // a request held into a stall must be ignored, error flag included
    task automatic t_refuse;
        @(posedge clk);
        req <= 1'h1;
        wr  <= 1'h1;
        tgt <= 4'h1;
        @(posedge clk);
        stop <= 1'h1;
        @(posedge clk);
        #1 cmp_b("refused error", 1'h0, err);
        cmp_b("stall held", 1'h1, wt);
        @(posedge clk);
        req  <= 1'h0;
        stop <= 1'h0;
        #1 cmp_b("refused error", 1'h0, err);
        @(posedge clk);
        #1 cmp_b("stall ended", 1'h0, wt);
        $display("refused request done");
    endtask : t_refuse
    task automatic t_stop;
        // software breaks the rule on purpose
        @(posedge clk);
        stop <= 1'h1;
        access(1'h1, 4'h1, 3, 1'h1);
        access(1'h0, 4'h0, 0, 1'h0);
        @(posedge clk);
        stop <= 1'h0;
        $display("clock stop access done");
    endtask : t_stop
    initial begin
        // stop stays low around stalling accesses except in t_refuse and t_stop, which raise it
        {rst_n, req, wr, speed, stop, go} = 6'h00;
        tgt   = 4'h0;
        shift = 3'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        t_fixed;
        t_conv;
        t_buf;
        t_refuse;
        t_stop;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up;
    end
endmodule : pbwg_wait_gen_tb
bind pbwg_wait_gen pbwg_wait_gen_asserts #(.BUF_MACRO_DIV(BUF_MACRO_DIV)) chk (
    .clock_i(clock_i), .resetn_i(resetn_i), .access_req_i(access_req_i),
    .access_write_i(access_write_i), .access_target_i(access_target_i),
    .converter_speed_select_i(converter_speed_select_i), .cpu_clock_shift_i(cpu_clock_shift_i),
    .main_clock_stop_bit_i(main_clock_stop_bit_i), .macro_buf_write_i(macro_buf_write_i),
    .wait_o(wait_o), .access_error_o(access_error_o));

// *** core/pbwg_pkg.sv ***
// constants shared by the peripheral bus wait generator
// assumes one cpu clock domain; the macro clock is known only as a divider of the system clock
package pbwg_pkg;

    localparam int unsigned CNT_W        = 8;
    localparam int unsigned DIV_W        = 4;
    localparam int unsigned SHIFT_W      = 3;
    localparam int unsigned PER_W        = 3;

    // fixed stalls and counter constants, in cpu clocks
    localparam logic [7:0]  WDT_WAIT     = 8'h03;
    localparam logic [7:0]  UART_WAIT    = 8'h01;
    localparam logic [7:0]  NO_WAIT      = 8'h00;
    localparam logic [7:0]  ONE_WAIT     = 8'h01;
    localparam logic [7:0]  ELAPSED_RST  = 8'hFF;

    // macro periods in the converter and buffer formulas
    localparam logic [2:0]  CONV_PERIODS = 3'h2;
    localparam logic [2:0]  BUF_PERIODS  = 3'h5;

    // converter macro clock divider of the system clock, per speed select, then the default buffer macro divider
    localparam logic [3:0]  CONV_DIV_FAST = 4'h2;
    localparam logic [3:0]  CONV_DIV_SLOW = 4'h4;
    localparam logic [3:0]  BUF_DIV_DEF   = 4'h8;

    // register targets as decoded by the cpu bus
    typedef enum logic [3:0] {
        TGT_OTHER          = 4'h0,
        TGT_WATCHDOG_MODE  = 4'h1,
        TGT_UART_CH0_RXST  = 4'h2,
        TGT_UART_CH6_RXST  = 4'h3,
        TGT_CONV_MODE      = 4'h4,
        TGT_CONV_IN_SEL    = 4'h5,
        TGT_PF_CMP_MODE    = 4'h6,
        TGT_PF_THRESHOLD   = 4'h7,
        TGT_CONV_RESULT    = 4'h8,
        TGT_BUFFER_RAM     = 4'h9
    } pbwg_target_type;

    // gray coded along idle -> stall -> idle
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_STALL = 2'b01
    } pbwg_state_type;

endpackage : pbwg_pkg

// *** core/pbwg_wait_calc.sv ***
// wait count formula: periods * macro period in cpu clocks, plus one
// assumes a cpu clock of 50 % duty, so the low width is half a cpu period
`timescale 1ns/100ps

module pbwg_wait_calc (
    input  wire logic [pbwg_pkg::PER_W-1:0]   periods_i,
    input  wire logic [pbwg_pkg::DIV_W-1:0]   macro_div_i,
    input  wire logic [pbwg_pkg::SHIFT_W-1:0] cpu_shift_i,
    output logic      [pbwg_pkg::CNT_W-1:0]   count_o
);

    // product and remainder in system clock periods
    wire logic [pbwg_pkg::CNT_W-1:0] product;
    wire logic [pbwg_pkg::CNT_W-1:0] quotient;
    wire logic [pbwg_pkg::CNT_W-1:0] rem_mask;
    wire logic [pbwg_pkg::CNT_W-1:0] remainder;
    wire logic [pbwg_pkg::CNT_W:0]   rem_twice;
    wire logic [pbwg_pkg::CNT_W:0]   cpu_period;
    wire logic                       round_up;

    assign product    = pbwg_pkg::CNT_W'(periods_i) * pbwg_pkg::CNT_W'(macro_div_i);
    assign quotient   = product >> cpu_shift_i;
    assign rem_mask   = pbwg_pkg::CNT_W'((9'h001 << cpu_shift_i) - 9'h001);
    assign remainder  = product & rem_mask;
    assign rem_twice  = {remainder, 1'b0};
    assign cpu_period = 9'h001 << cpu_shift_i;
    // R10 truncate unless beyond low width
    assign round_up   = rem_twice > cpu_period;
    // R8 formula plus one
    assign count_o    = quotient + pbwg_pkg::CNT_W'(round_up) + pbwg_pkg::ONE_WAIT;

endmodule : pbwg_wait_calc

// *** core/pbwg_wait_gen.sv ***
// wait generator between the cpu bus and the low-speed peripheral bus
// assumes access_req_i is a one-cycle strobe from the cpu, issued only while wait_o is low
// assumes software keeps main_clock_stop_bit_i low around any stalling access
// cpu clock shifts above four simply follow the same formula
//
// Contract
// R1: hold cpu in wait until data valid
// R2: all waits counted in cpu clocks
// R3: watchdog mode write stalls three clocks
// R4: uart receive status read stalls one
// R5: converter writes stall 2..5 when fast
// R6: converter writes stall 2..9 when slow
// R7: result read stalls 1..5 or 1..9
// R8: max wait two macro periods plus one
// R9: macro clock half or quarter system clock
// R10: fraction truncated below low width, else up; the code also truncates a fraction of exactly the low width
// R11: count one gives no write wait
// R12: no wait access while main clock stopped
// R13: buffer write stall 0..41, five periods
// R14: no buffer wait after five macro clocks
// R15: other accesses complete without wait
`timescale 1ns/100ps

module pbwg_wait_gen #(
    parameter logic [pbwg_pkg::DIV_W-1:0] BUF_MACRO_DIV = pbwg_pkg::BUF_DIV_DEF
) (
    input  wire logic                         clock_i,
    input  wire logic                         resetn_i,
    input  wire logic                         access_req_i,
    input  wire logic                         access_write_i,
    input  wire logic [3:0]                   access_target_i,
    input  wire logic                         converter_speed_select_i,
    input  wire logic [pbwg_pkg::SHIFT_W-1:0] cpu_clock_shift_i,
    input  wire logic                         main_clock_stop_bit_i,
    input  wire logic                         macro_buf_write_i,
    output logic                              wait_o,
    output logic                              access_error_o
);

    ////////////////////////////////////////////////////////////////////////////
    // wait lengths

    wire logic [pbwg_pkg::DIV_W-1:0] conv_div;
    wire logic [pbwg_pkg::CNT_W-1:0] conv_count;
    wire logic [pbwg_pkg::CNT_W-1:0] buf_max;
    wire logic [pbwg_pkg::CNT_W-1:0] buf_guard;

    // R9 converter macro clock divider
    assign conv_div = converter_speed_select_i ? pbwg_pkg::CONV_DIV_FAST
                                               : pbwg_pkg::CONV_DIV_SLOW;

    // R5 R6 R7 converter wait count
    pbwg_wait_calc u_conv_calc (
        .periods_i   (pbwg_pkg::CONV_PERIODS),
        .macro_div_i (conv_div),
        .cpu_shift_i (cpu_clock_shift_i),
        .count_o     (conv_count)
    );

    // R13 buffer ram maximum wait
    pbwg_wait_calc u_buf_calc (
        .periods_i   (pbwg_pkg::BUF_PERIODS),
        .macro_div_i (BUF_MACRO_DIV),
        .cpu_shift_i (cpu_clock_shift_i),
        .count_o     (buf_max)
    );

    // five macro periods: a cpu write this far after a macro write runs free
    assign buf_guard = buf_max - pbwg_pkg::ONE_WAIT;

    ////////////////////////////////////////////////////////////////////////////
    // time since the macro last wrote the buffer ram

    logic [pbwg_pkg::CNT_W-1:0]      elapsed;
    wire logic [pbwg_pkg::CNT_W-1:0] next_elapsed;
    wire logic [pbwg_pkg::CNT_W-1:0] elapsed_now;
    wire logic                       elapsed_full;

    // saturates so a long quiet spell never wraps into a false stall
    assign elapsed_full = elapsed == pbwg_pkg::ELAPSED_RST;
    // the cycle after a macro write is already one clock away from it
    assign next_elapsed = macro_buf_write_i ? pbwg_pkg::ONE_WAIT :
                          elapsed_full      ? elapsed :
                          elapsed + pbwg_pkg::ONE_WAIT;
    // a macro write in the same cycle counts as no time passed
    assign elapsed_now  = macro_buf_write_i ? pbwg_pkg::NO_WAIT : elapsed;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            elapsed <= pbwg_pkg::ELAPSED_RST;
        end else begin
            elapsed <= next_elapsed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode of the access into a stall length

    wire logic                       is_read;
    wire logic                       hit_conv_reg;
    wire logic                       is_conv_wr;
    wire logic                       conv_is_one;
    wire logic                       buf_busy;
    wire logic [pbwg_pkg::CNT_W-1:0] conv_wr_len;
    wire logic [pbwg_pkg::CNT_W-1:0] buf_len;
    logic      [pbwg_pkg::CNT_W-1:0] req_len;

    assign is_read      = !access_write_i;
    assign hit_conv_reg = access_target_i == pbwg_pkg::TGT_CONV_MODE ||
                          access_target_i == pbwg_pkg::TGT_CONV_IN_SEL ||
                          access_target_i == pbwg_pkg::TGT_PF_CMP_MODE ||
                          access_target_i == pbwg_pkg::TGT_PF_THRESHOLD;
    assign is_conv_wr   = access_write_i && hit_conv_reg;
    assign conv_is_one  = conv_count == pbwg_pkg::ONE_WAIT;
    // R11 single-clock count drops write wait
    assign conv_wr_len  = conv_is_one ? pbwg_pkg::NO_WAIT : conv_count;
    // R14 quiet for five macro clocks
    assign buf_busy    = elapsed_now < buf_guard;
    // R13 remaining guard plus one
    assign buf_len     = buf_busy ? buf_max - elapsed_now : pbwg_pkg::NO_WAIT;

    always_comb begin
        req_len = pbwg_pkg::NO_WAIT;
        case (access_target_i)
            // R3 fixed watchdog stall
            pbwg_pkg::TGT_WATCHDOG_MODE: begin
                req_len = access_write_i ? pbwg_pkg::WDT_WAIT : pbwg_pkg::NO_WAIT;
            end
            // R4 fixed uart status stall
            pbwg_pkg::TGT_UART_CH0_RXST,
            pbwg_pkg::TGT_UART_CH6_RXST: begin
                req_len = is_read ? pbwg_pkg::UART_WAIT : pbwg_pkg::NO_WAIT;
            end
            pbwg_pkg::TGT_CONV_MODE,
            pbwg_pkg::TGT_CONV_IN_SEL,
            pbwg_pkg::TGT_PF_CMP_MODE,
            pbwg_pkg::TGT_PF_THRESHOLD: begin
                req_len = is_conv_wr ? conv_wr_len : pbwg_pkg::NO_WAIT;
            end
            // R7 result read never below one
            pbwg_pkg::TGT_CONV_RESULT: begin
                req_len = is_read ? conv_count : pbwg_pkg::NO_WAIT;
            end
            pbwg_pkg::TGT_BUFFER_RAM: begin
                req_len = access_write_i ? buf_len : pbwg_pkg::NO_WAIT;
            end
            // R15 everything else runs free
            default: begin
                req_len = pbwg_pkg::NO_WAIT;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // stall sequencer

    pbwg_pkg::pbwg_state_type        state;
    pbwg_pkg::pbwg_state_type        next_state;
    logic [pbwg_pkg::CNT_W-1:0]      remain;
    logic [pbwg_pkg::CNT_W-1:0]      next_remain;
    wire logic [pbwg_pkg::CNT_W-1:0] dec_remain;
    wire logic                       is_idle;
    wire logic                       take;
    wire logic                       last;
    wire logic                       next_wait;
    wire logic                       next_error;

    assign is_idle    = state == pbwg_pkg::ST_IDLE;
    // a request made during a stall is refused, so it may not raise the flag
    assign take       = access_req_i && is_idle && (req_len != pbwg_pkg::NO_WAIT);
    assign last       = remain == pbwg_pkg::ONE_WAIT;
    assign dec_remain = remain - pbwg_pkg::ONE_WAIT;
    // taken from the next state so the stall shows right after the taking edge
    assign next_wait  = next_state == pbwg_pkg::ST_STALL;
    // flags a stalling access made while the system clock is stopped; the stall still runs
    // R12 software must avoid this access
    assign next_error = take && main_clock_stop_bit_i;

    always_comb begin
        next_state  = state;
        next_remain = remain;
        case (state)
            pbwg_pkg::ST_IDLE: begin
                if (take) begin
                    next_state  = pbwg_pkg::ST_STALL;
                    next_remain = req_len;
                end
            end
            // R1 R2 hold one cpu clock per count
            pbwg_pkg::ST_STALL: begin
                next_remain = dec_remain;
                if (last) begin
                    next_state = pbwg_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state  = pbwg_pkg::ST_IDLE;
                next_remain = pbwg_pkg::NO_WAIT;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state  <= pbwg_pkg::ST_IDLE;
            remain <= pbwg_pkg::NO_WAIT;
        end else begin
            state  <= next_state;
            remain <= next_remain;
        end
    end

    // both outputs leave straight from flops
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_o         <= 1'b0;
            access_error_o <= 1'b0;
        end else begin
            wait_o         <= next_wait;
            access_error_o <= next_error;
        end
    end

endmodule : pbwg_wait_gen
